// ---- src/isr_pkg.sv ----
/*
 * isr_pkg: shared constants and types for the two-wire target port.
 * assumes: included by every design file; nothing imported, all uses scoped.
 */
package isr_pkg;

    // ------------------------------------------------------------
    // constants
    // ------------------------------------------------------------
    localparam int          BYTE_BITS   = 8;
    localparam logic [3:0]  BIT_LAST    = 4'h8;
    localparam logic [3:0]  BIT_ZERO    = 4'h0;
    localparam logic [3:0]  BIT_STEP    = 4'h1;
    localparam logic [4:0]  HI_PREFIX   = 5'h1e;
    localparam logic [7:0]  BYTE_ZERO   = 8'h00;
    localparam int          SYNC_STAGES = 3;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_ACK, ST_TXWAIT, ST_TX, ST_TXACK} isr_state_t;
    typedef enum logic [1:0] {PH_ADDR, PH_LO, PH_DATA} isr_phase_t;

    typedef struct packed {
        logic ten_bit;
        logic stretch_enable;
        logic address_hold_enable;
        logic data_hold_enable;
        logic buffer_overwrite_enable;
        logic slave_collision_detect_enable;
        logic start_irq_enable;
        logic stop_irq_enable;
    } isr_cfg_t;

    typedef struct packed {
        logic       own_address_wr;
        logic [7:0] own_address_data;
        logic       clock_release_set;
        logic       irq_clear;
        logic       collision_irq_clear;
        logic       overflow_clear;
        logic       ack_value_select;
    } isr_sw_t;

    typedef struct packed {
        logic update_address_flag;
        logic port_irq_flag;
        logic buffer_full_flag;
        logic receive_overflow_flag;
        logic clock_release_bit;
        logic ack_time_flag;
        logic ack_received_status;
        logic collision_irq_flag;
        logic start_seen;
        logic stop_seen;
        logic read_not_write;
        logic data_not_address;
    } isr_status_t;

    // hold_req is the inverse of the clock-release bit so that reset is all zero
    typedef struct packed {
        isr_state_t state;
        isr_phase_t phase;
        logic [3:0] cnt;
        logic [7:0] shift;
        logic [7:0] own_addr;
        logic       hold;
        logic       auto_nack;
        logic       ua_pend;
        logic       go_read;
        logic       hold_req;
        logic       armed;
        logic       ua;
        logic       irq;
        logic       ov;
        logic       ack_time;
        logic       ack_rx;
        logic       bcl;
        logic       start_seen;
        logic       stop_seen;
        logic       rw;
        logic       da;
        logic       prior;
        logic       sda_low;
        logic       tx_ready;
    } isr_core_t;

endpackage

// ---- src/isr_target.sv ----
/*
 * isr_target: two-wire bus target with 7/10-bit address match, receive
 * through a two-entry buffer, transmit with stretching, collision detect.
 * assumes: open-drain pads outside resolve the wires from the enables;
 * software strobes are one-cycle pulses on clk; bus clock far below clk.
 */
`timescale 1ns/1ns
module isr_target (
    // clock and reset
    input  logic                clk,
    input  logic                resetn,
    // bus pins, open drain, enables active low
    input  logic                scl_i,
    input  logic                sda_i,
    output logic                scl_o,
    output logic                scl_oe_n,
    output logic                sda_o,
    output logic                sda_oe_n,
    // software control and status
    input  isr_pkg::isr_cfg_t   cfg,
    input  isr_pkg::isr_sw_t    sw,
    output isr_pkg::isr_status_t status,
    // received bytes
    output logic                rx_valid,
    input  logic                rx_ready,
    output logic [7:0]          rx_data,
    // transmit bytes
    input  logic                tx_valid,
    output logic                tx_ready,
    input  logic [7:0]          tx_data
);

    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    logic [isr_pkg::SYNC_STAGES-1:0] scl_sync_q;
    logic [isr_pkg::SYNC_STAGES-1:0] sda_sync_q;
    logic                            scl_q, sda_q, scl_prev_q, sda_prev_q;
    logic                            scl_d, sda_d;

    always_comb begin
        scl_d = (scl_sync_q[1] == scl_sync_q[2]) ? scl_sync_q[2] : scl_q;
        sda_d = (sda_sync_q[1] == sda_sync_q[2]) ? sda_sync_q[2] : sda_q;
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            scl_sync_q <= '1;
            sda_sync_q <= '1;
            scl_q      <= 1'b1;
            sda_q      <= 1'b1;
            scl_prev_q <= 1'b1;
            sda_prev_q <= 1'b1;
        end else begin
            scl_sync_q <= {scl_sync_q[1:0], scl_i};
            sda_sync_q <= {sda_sync_q[1:0], sda_i};
            scl_q      <= scl_d;
            sda_q      <= sda_d;
            scl_prev_q <= scl_q;
            sda_prev_q <= sda_q;
        end
    end

    logic scl_rise, scl_fall, bus_start, bus_stop;
    assign scl_rise  = scl_q & ~scl_prev_q;
    assign scl_fall  = ~scl_q & scl_prev_q;
    assign bus_start = scl_q & scl_prev_q & sda_prev_q & ~sda_q;
    assign bus_stop  = scl_q & scl_prev_q & ~sda_prev_q & sda_q;

    // ------------------------------------------------------------
    // receive buffer, two entries
    // ------------------------------------------------------------
    logic       head_v_q, tail_v_q, head_v_d, tail_v_d;
    logic [7:0] head_q, tail_q, head_d, tail_d;
    logic       push;
    logic [7:0] push_data;
    logic       pop;

    assign pop = head_v_q & rx_ready;

    always_comb begin
        head_v_d = head_v_q;
        tail_v_d = tail_v_q;
        head_d   = head_q;
        tail_d   = tail_q;
        if (pop) begin
            head_d   = tail_q;
            head_v_d = tail_v_q;
            tail_v_d = 1'b0;
        end
        if (push) begin
            if (!head_v_d) begin
                head_d   = push_data;
                head_v_d = 1'b1;
            end else begin
                tail_d   = push_data;
                tail_v_d = 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            head_v_q <= 1'b0;
            tail_v_q <= 1'b0;
            head_q   <= isr_pkg::BYTE_ZERO;
            tail_q   <= isr_pkg::BYTE_ZERO;
        end else begin
            head_v_q <= head_v_d;
            tail_v_q <= tail_v_d;
            head_q   <= head_d;
            tail_q   <= tail_d;
        end
    end

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    function automatic logic hi_match(input logic [7:0] b, input logic [7:0] own);
        hi_match = (b[7:3] == isr_pkg::HI_PREFIX) && (b[2:1] == own[2:1]);
    endfunction

    // ------------------------------------------------------------
    // protocol core
    // ------------------------------------------------------------
    isr_pkg::isr_core_t core_q, core_d;
    logic               nack_w;
    logic [7:0]         rx_byte;
    logic               seven_ok, hi_ok, byte_ok, busy, hold_mode;

    // in hold modes the ack level follows software live until the ninth fall
    assign nack_w  = core_q.hold ? sw.ack_value_select : core_q.auto_nack;
    assign rx_byte = core_q.shift;

    always_comb begin
        core_d    = core_q;
        push      = 1'b0;
        push_data = rx_byte;
        seven_ok  = ~cfg.ten_bit && (rx_byte[7:1] == core_q.own_addr[7:1]);
        hi_ok     = cfg.ten_bit && hi_match(rx_byte, core_q.own_addr);
        busy      = core_q.ov | (head_v_q & ~cfg.buffer_overwrite_enable) | tail_v_q;
        hold_mode = (core_q.phase == isr_pkg::PH_DATA) ? cfg.data_hold_enable
                                                       : cfg.address_hold_enable;
        case (core_q.phase)
            isr_pkg::PH_ADDR: byte_ok = seven_ok | (hi_ok & (~rx_byte[0] | core_q.prior));
            isr_pkg::PH_LO:   byte_ok = (rx_byte == core_q.own_addr);
            default:          byte_ok = 1'b1;
        endcase

        // software side; hardware sets below override these clears
        if (sw.own_address_wr) begin
            core_d.own_addr = sw.own_address_data;
            core_d.ua       = 1'b0;
        end
        if (sw.clock_release_set) core_d.hold_req = 1'b0;
        if (sw.irq_clear) core_d.irq = 1'b0;
        if (sw.collision_irq_clear) core_d.bcl = 1'b0;
        if (sw.overflow_clear) core_d.ov = 1'b0;

        case (core_q.state)
            isr_pkg::ST_RX: begin
                if (scl_rise) begin
                    core_d.shift = {core_q.shift[6:0], sda_q};
                    core_d.cnt   = 4'(core_q.cnt + isr_pkg::BIT_STEP);
                end
                if (scl_fall && core_q.cnt == isr_pkg::BIT_LAST) begin
                    if (core_q.phase == isr_pkg::PH_ADDR && cfg.ten_bit &&
                        (!hi_ok || !rx_byte[0])) core_d.prior = 1'b0;
                    if (byte_ok || core_q.phase == isr_pkg::PH_LO) begin
                        push           = byte_ok & ~busy;
                        if (byte_ok && busy) core_d.ov = 1'b1;
                        core_d.auto_nack = ~byte_ok | busy;
                        core_d.hold      = hold_mode & byte_ok;
                        core_d.ua_pend   = (core_q.phase == isr_pkg::PH_LO) |
                                           (core_q.phase == isr_pkg::PH_ADDR & hi_ok & ~rx_byte[0]);
                        core_d.go_read   = (core_q.phase == isr_pkg::PH_ADDR) & rx_byte[0];
                        if (core_q.phase == isr_pkg::PH_ADDR) begin
                            core_d.rw = rx_byte[0];
                            core_d.da = 1'b0;
                        end else if (core_q.phase == isr_pkg::PH_DATA) begin
                            core_d.da = 1'b1;
                        end
                        if (hold_mode && byte_ok) begin
                            core_d.irq      = 1'b1;
                            core_d.hold_req = 1'b1;
                            core_d.ack_time = 1'b1;
                        end
                        core_d.state = isr_pkg::ST_ACK;
                    end else begin
                        core_d.state = isr_pkg::ST_IDLE;
                    end
                end
            end
            isr_pkg::ST_ACK: begin
                core_d.sda_low = ~nack_w;
                if (scl_fall) begin
                    core_d.sda_low  = 1'b0;
                    core_d.ack_time = 1'b0;
                    core_d.cnt      = isr_pkg::BIT_ZERO;
                    if (!nack_w || core_q.ua_pend) core_d.irq = 1'b1;
                    if (core_q.ua_pend) core_d.ua = 1'b1;
                    if (nack_w) begin
                        core_d.state = isr_pkg::ST_IDLE;
                    end else if (core_q.go_read) begin
                        core_d.hold_req = 1'b1;
                        core_d.tx_ready = 1'b1;
                        core_d.state    = isr_pkg::ST_TXWAIT;
                    end else begin
                        core_d.state = isr_pkg::ST_RX;
                        if (core_q.phase == isr_pkg::PH_LO) core_d.prior = 1'b1;
                        core_d.phase = core_q.ua_pend && core_q.phase == isr_pkg::PH_ADDR
                                       ? isr_pkg::PH_LO : isr_pkg::PH_DATA;
                        if (cfg.stretch_enable && !core_q.ua_pend) core_d.hold_req = 1'b1;
                    end
                end
            end
            isr_pkg::ST_TXWAIT: begin
                if (tx_valid && core_q.tx_ready) begin
                    core_d.shift    = tx_data;
                    core_d.sda_low  = ~tx_data[7];
                    core_d.tx_ready = 1'b0;
                    core_d.state    = isr_pkg::ST_TX;
                    core_d.cnt      = isr_pkg::BIT_ZERO;
                end
            end
            isr_pkg::ST_TX: begin
                if (scl_rise) begin
                    if (!core_q.sda_low && !sda_q && cfg.slave_collision_detect_enable) begin
                        core_d.bcl     = 1'b1;
                        core_d.sda_low = 1'b0;
                        core_d.state   = isr_pkg::ST_IDLE;
                    end else begin
                        core_d.cnt = 4'(core_q.cnt + isr_pkg::BIT_STEP);
                    end
                end
                if (scl_fall) begin
                    if (core_q.cnt == isr_pkg::BIT_LAST) begin
                        core_d.sda_low = 1'b0;
                        core_d.state   = isr_pkg::ST_TXACK;
                    end else begin
                        core_d.shift   = {core_q.shift[6:0], 1'b0};
                        core_d.sda_low = ~core_q.shift[6];
                    end
                end
            end
            isr_pkg::ST_TXACK: begin
                if (scl_rise) core_d.ack_rx = sda_q;
                if (scl_fall) begin
                    core_d.irq = 1'b1;
                    if (core_q.ack_rx) begin
                        core_d.state = isr_pkg::ST_IDLE;
                    end else begin
                        core_d.hold_req = 1'b1;
                        core_d.tx_ready = 1'b1;
                        core_d.state    = isr_pkg::ST_TXWAIT;
                    end
                end
            end
            default: begin
            end
        endcase

        // start or restart sends the state machine back to address receive whatever it was doing; hold_req, ua and prior are kept
        if (bus_start) begin
            core_d.state      = isr_pkg::ST_RX;
            core_d.phase      = isr_pkg::PH_ADDR;
            core_d.cnt        = isr_pkg::BIT_ZERO;
            core_d.sda_low    = 1'b0;
            core_d.tx_ready   = 1'b0;
            core_d.start_seen = 1'b1;
            core_d.stop_seen  = 1'b0;
            if (cfg.start_irq_enable) core_d.irq = 1'b1;
        end else if (bus_stop) begin
            core_d.state      = isr_pkg::ST_IDLE;
            core_d.sda_low    = 1'b0;
            core_d.tx_ready   = 1'b0;
            core_d.prior      = 1'b0;
            core_d.stop_seen  = 1'b1;
            core_d.start_seen = 1'b0;
            if (cfg.stop_irq_enable) core_d.irq = 1'b1;
        end

        // never pull the clock before it is seen low: keeps the high time intact
        core_d.armed = core_d.hold_req & (core_q.armed | ~scl_q);
    end

    always_ff @(posedge clk) begin
        if (!resetn) core_q <= '0;
        else core_q <= core_d;
    end

    // ------------------------------------------------------------
    // pin and status outputs
    // ------------------------------------------------------------
    logic scl_oe_n_q, sda_oe_n_q, scl_oe_n_d, sda_oe_n_d;

    always_comb begin
        scl_oe_n_d = ~((core_q.hold_req & core_q.armed) | core_q.ua);
        sda_oe_n_d = ~core_q.sda_low;
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            scl_oe_n_q <= 1'b1;
            sda_oe_n_q <= 1'b1;
        end else begin
            scl_oe_n_q <= scl_oe_n_d;
            sda_oe_n_q <= sda_oe_n_d;
        end
    end

    assign scl_o    = 1'b0;
    assign sda_o    = 1'b0;
    assign scl_oe_n = scl_oe_n_q;
    assign sda_oe_n = sda_oe_n_q;
    assign rx_valid = head_v_q;
    assign rx_data  = head_q;
    assign tx_ready = core_q.tx_ready;
    assign status   = '{update_address_flag:   core_q.ua,
                        port_irq_flag:         core_q.irq,
                        buffer_full_flag:      head_v_q,
                        receive_overflow_flag: core_q.ov,
                        clock_release_bit:     ~core_q.hold_req,
                        ack_time_flag:         core_q.ack_time,
                        ack_received_status:   core_q.ack_rx,
                        collision_irq_flag:    core_q.bcl,
                        start_seen:            core_q.start_seen,
                        stop_seen:             core_q.stop_seen,
                        read_not_write:        core_q.rw,
                        data_not_address:      core_q.da};

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    property p_ua_holds_scl;
        core_q.ua |=> !scl_oe_n_q;
    endproperty
    a_ua_holds_scl: assert property (p_ua_holds_scl) else $error("clock not held with ua");

    property p_addr_wr_clears_ua;
        sw.own_address_wr && !(core_q.state == isr_pkg::ST_ACK && scl_fall) |=> !core_q.ua;
    endproperty
    a_addr_wr_clears_ua: assert property (p_addr_wr_clears_ua) else $error("ua not cleared");

    property p_no_early_stretch;
        core_q.hold_req && !core_q.armed && !core_q.ua |=> scl_oe_n_q;
    endproperty
    a_no_early_stretch: assert property (p_no_early_stretch) else $error("early stretch");

    property p_irq_sticky;
        core_q.irq && !sw.irq_clear |=> core_q.irq;
    endproperty
    a_irq_sticky: assert property (p_irq_sticky) else $error("irq flag lost");

    property p_collision;
        core_q.state == isr_pkg::ST_TX && scl_rise && !core_q.sda_low && !sda_q &&
        cfg.slave_collision_detect_enable && !bus_start && !bus_stop
        |=> core_q.bcl && core_q.state == isr_pkg::ST_IDLE;
    endproperty
    a_collision: assert property (p_collision) else $error("collision missed");

    property p_ack_latch;
        core_q.state == isr_pkg::ST_TXACK && scl_rise |=> core_q.ack_rx == $past(sda_q);
    endproperty
    a_ack_latch: assert property (p_ack_latch) else $error("ack not latched");

    property p_tx_irq;
        core_q.state == isr_pkg::ST_TXACK && scl_fall |=> core_q.irq;
    endproperty
    a_tx_irq: assert property (p_tx_irq) else $error("no irq after ninth fall");

    property p_read_stretch;
        core_q.state == isr_pkg::ST_ACK && scl_fall && core_q.go_read && !nack_w &&
        !bus_start && !bus_stop && !sw.clock_release_set
        |=> core_q.hold_req && tx_ready ##1 !tx_ready || core_q.hold_req;
    endproperty
    a_read_stretch: assert property (p_read_stretch) else $error("read not stretched");

    property p_start_seen;
        bus_start |=> core_q.start_seen && core_q.state == isr_pkg::ST_RX;
    endproperty
    a_start_seen: assert property (p_start_seen) else $error("start not seen");

    property p_busy_nack;
        core_q.state == isr_pkg::ST_RX && scl_fall && core_q.cnt == isr_pkg::BIT_LAST &&
        core_q.ov && (byte_ok || core_q.phase == isr_pkg::PH_LO) && !bus_start && !bus_stop
        |=> core_q.auto_nack;
    endproperty
    a_busy_nack: assert property (p_busy_nack) else $error("acked while overflow");

    c_write_byte: cover property (core_q.phase == isr_pkg::PH_DATA && push);
    c_read_byte:  cover property (core_q.state == isr_pkg::ST_TXACK && scl_fall);
    c_lo_phase:   cover property (core_q.phase == isr_pkg::PH_LO && core_q.state == isr_pkg::ST_ACK);
    c_collide:    cover property (core_q.bcl);

endmodule

// ---- tb/isr_ctrl_model.sv ----
/* isr_ctrl_model: two-wire bus controller driving the bit clock.
   assumes: wires are wired-and with pull-ups outside; clk is 4 ns. */
`timescale 1ns/1ns
module isr_ctrl_model (
    input  wire logic clk,
    input  wire logic scl_w,
    input  wire logic sda_w,
    output logic      scl_m = 1'b1,
    output logic      sda_m = 1'b1
);
    task automatic half();
        repeat (4) @(posedge clk);
    endtask
    // a stretching target holds the low phase; bounded wait
    task automatic rise();
        scl_m <= 1'b1;
        for (int n = 0; n < 9999 && scl_w !== 1'b1; n++) @(posedge clk);
        half();
    endtask
    task automatic start();
        @(posedge clk);
        sda_m <= 1'b1;
        half();
        rise();
        sda_m <= 1'b0;
        half();
        scl_m <= 1'b0;
    endtask
    task automatic stop();
        @(posedge clk);
        sda_m <= 1'b0;
        half();
        rise();
        sda_m <= 1'b1;
        half();
    endtask
    // msb first; data moves only while the clock is low
    task automatic bits(input logic [8:0] d, input int n, output logic [8:0] q);
        q = 9'h000;
        for (int i = n - 1; i >= 0; i--) begin
            @(posedge clk);
            sda_m <= d[i];
            // long low phase: the target's ack and data lag a fall by ~7 clocks
            repeat (8) @(posedge clk);
            rise();
            q[i] = sda_w;
            scl_m <= 1'b0;
        end
    endtask
endmodule

// ---- tb/testbench.sv ----
/* testbench: two-wire target under a controller model and software strobes.
   assumes: isr_pkg, isr_target and isr_ctrl_model compiled before. */
`timescale 1ns/1ns
module testbench;
    localparam logic [4:0] AWR = 5'h10, REL = 5'h08, ICLR = 5'h04, OCLR = 5'h01;
    logic                 clk = 1'b0, resetn = 1'b0, rx_ready = 1'b0, tx_valid = 1'b0;
    logic                 scl_m, sda_m, scl_o, sda_o, scl_oe_n, sda_oe_n, rx_valid, tx_ready;
    logic [7:0]           rx_data, tx_data = 8'h00;
    logic [8:0]           q;
    isr_pkg::isr_cfg_t    cfg = '0;
    isr_pkg::isr_sw_t     sw = '0;
    isr_pkg::isr_status_t status;
    int                   miscompares = 0, n_checks = 0;
    wire                  scl_w = scl_m & (scl_oe_n | scl_o);
    wire                  sda_w = sda_m & (sda_oe_n | sda_o);
    isr_target i_isr_target (.clk(clk), .resetn(resetn), .scl_i(scl_w), .sda_i(sda_w),
        .scl_o(scl_o), .scl_oe_n(scl_oe_n), .sda_o(sda_o), .sda_oe_n(sda_oe_n), .cfg(cfg),
        .sw(sw), .status(status), .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data),
        .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data));
    isr_ctrl_model i_isr_ctrl_model (.clk(clk), .scl_w(scl_w), .sda_w(sda_w), .scl_m(scl_m),
        .sda_m(sda_m));
    always #2 clk = ~clk;
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [11:0] e, input logic [11:0] g);
        n_checks++;
        if (g !== e) begin
            miscompares++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    // checks land at the falling edge, clear of the sampling edge
    task automatic settle();
        repeat (10) @(posedge clk);
        @(negedge clk);
    endtask
    task automatic strobe(input logic [4:0] m, input logic [7:0] a);
        @(posedge clk);
        {sw.own_address_wr, sw.clock_release_set, sw.irq_clear, sw.overflow_clear} <= {m[4:2], m[0]};
        sw.own_address_data <= a;
        @(posedge clk);
        {sw.own_address_wr, sw.clock_release_set, sw.irq_clear, sw.overflow_clear} <= 4'h0;
        settle();
    endtask
    task automatic byte_io(input logic [8:0] d, input int n);
        i_isr_ctrl_model.bits(d, n, q);
        settle();
    endtask
    task automatic pop(input logic [7:0] e);
        chk("rx_head", {4'h1, e}, 12'({rx_valid, rx_data}));
        @(posedge clk);
        rx_ready <= 1'b1;
        @(posedge clk);
        rx_ready <= 1'b0;
        @(negedge clk);
    endtask
    // load, release, read back with a closing nack
    task automatic tx_byte(input logic [7:0] d);
        @(posedge clk);
        tx_valid <= 1'b1;
        tx_data <= d;
        @(posedge clk);
        tx_valid <= 1'b0;
        strobe(ICLR | REL, 8'h00);
        byte_io(9'h1ff, 9);
        chk("tx_byte", {4'h0, d}, 12'(q[8:1]));
        chk("tx_nack", 12'h4a0, status & 12'h4a0);
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_rx7();
        chk("reset_status", 12'h080, status);
        strobe(AWR, 8'h54);
        i_isr_ctrl_model.start();
        byte_io({8'h54, 1'b1}, 9);
        chk("addr_wr", 12'h688, status & 12'hf8f | 12'(q[0]));
        strobe(ICLR, 8'h00);
        byte_io({8'ha5, 1'b1}, 9);
        chk("data_1", 12'h601, status & 12'h701 | 12'(q[0]));
        byte_io({8'h3c, 1'b1}, 9);
        chk("data_full", 12'h101, status & 12'h100 | 12'(q[0]));
        pop(8'h54);
        pop(8'ha5);
        chk("drained", 12'h000, status & 12'h200);
        i_isr_ctrl_model.start();
        byte_io({8'h54, 1'b1}, 9);
        chk("addr_ov", 12'h001, 12'(q[0]));
        strobe(OCLR, 8'h00);
        i_isr_ctrl_model.stop();
        settle();
        chk("stop_seen", 12'h004, status & 12'h004);
        $display("test rx7 done");
    endtask
    task automatic t_hold();
        @(posedge clk);
        cfg.address_hold_enable <= 1'b1;
        rx_ready <= 1'b1;
        for (int v = 0; v < 2; v++) begin
            strobe(ICLR, 8'h00);
            i_isr_ctrl_model.start();
            byte_io({1'b0, 8'h54}, 8);
            chk("hold8", 12'h440, status & 12'h4c0);
            @(posedge clk);
            sw.ack_value_select <= v[0];
            strobe(ICLR | REL, 8'h00);
            byte_io(9'h001, 1);
            chk("ack9", 12'({v[0], ~v[0]}), 12'({q[0], status.port_irq_flag}));
            i_isr_ctrl_model.stop();
        end
        @(posedge clk);
        sw.ack_value_select <= 1'b0;
        cfg.address_hold_enable <= 1'b0;
        $display("test hold done");
    endtask
    task automatic t_tx7();
        strobe(ICLR, 8'h00);
        i_isr_ctrl_model.start();
        byte_io({8'h55, 1'b1}, 9);
        chk("rd_addr", 12'h403, status & 12'h483 | 12'({q[0], tx_ready}));
        tx_byte(8'hc3);
        i_isr_ctrl_model.stop();
        $display("test tx7 done");
    endtask
    task automatic t_bcl();
        @(posedge clk);
        cfg.stretch_enable <= 1'b1;
        cfg.slave_collision_detect_enable <= 1'b1;
        cfg.start_irq_enable <= 1'b1;
        strobe(ICLR, 8'h00);
        i_isr_ctrl_model.start();
        settle();
        chk("start_irq", 12'h400, status & 12'h400);
        strobe(ICLR, 8'h00);
        byte_io({8'h54, 1'b1}, 9);
        chk("stretch", 12'h400, status & 12'h480 | 12'(q[0]));
        strobe(REL, 8'h00);
        i_isr_ctrl_model.start();
        byte_io({8'h55, 1'b1}, 9);
        @(posedge clk);
        tx_valid <= 1'b1;
        tx_data <= 8'hff;
        @(posedge clk);
        tx_valid <= 1'b0;
        strobe(REL, 8'h00);
        byte_io(9'h0ff, 9);
        chk("collision", 12'h010, status & 12'h010 | 12'(q[8]));
        i_isr_ctrl_model.stop();
        @(posedge clk);
        cfg <= '0;
        $display("test bcl done");
    endtask
    task automatic t_ten();
        @(posedge clk);
        cfg.ten_bit <= 1'b1;
        strobe(AWR, 8'h04);
        i_isr_ctrl_model.start();
        byte_io({8'hf4, 1'b1}, 9);
        chk("hi_ack", 12'h800, status & 12'h800 | 12'(q[0]));
        strobe(AWR, 8'h5c);
        chk("ua_clear", 12'h000, status & 12'h800);
        byte_io({8'h5c, 1'b1}, 9);
        chk("lo_ack", 12'h800, status & 12'h800 | 12'(q[0]));
        strobe(AWR, 8'h04);
        i_isr_ctrl_model.start();
        byte_io({8'hf5, 1'b1}, 9);
        chk("rd10", 12'h002, status & 12'h002 | 12'(q[0]));
        tx_byte(8'h96);
        i_isr_ctrl_model.stop();
        i_isr_ctrl_model.start();
        byte_io({8'hf4, 1'b1}, 9);
        strobe(AWR | ICLR, 8'h5c);
        byte_io({8'h5d, 1'b1}, 9);
        chk("lo_miss", 12'hc00, status & 12'hc00);
        strobe(AWR, 8'h04);
        i_isr_ctrl_model.stop();
        $display("test ten done");
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge clk);
        resetn <= 1'b1;
        cfg.buffer_overwrite_enable <= 1'b1;
        settle();
        t_rx7();
        @(posedge clk);
        cfg.buffer_overwrite_enable <= 1'b0;
        t_hold();
        t_tx7();
        t_bcl();
        t_ten();
        end_of_test();
    end
    // a few thousand cycles expected; a stuck stretch ends here
    initial begin
        repeat (90000) @(posedge clk);
        miscompares++;
        end_of_test();
    end
endmodule
